// file: dps_pkg.sv
// Purpose: Shared constants and types for the dual input power path sequencer.
// Assumes: 10 MHz core clock, AHB-Lite register access with word-aligned registers.
// Notes:   Register indices are word indices; the byte address is four times the index.
`default_nettype none
package dps_pkg;
  // Clock rate and documented times, in their own units.
  localparam int CLK_HZ     = 10_000_000;
  localparam int T_READY_MS = 20;
  localparam int T_INTERNAL_BIAS_REGULATOR_MS  = 128;
  localparam int READY_CYC  = T_READY_MS * (CLK_HZ / 1000);
  localparam int INTERNAL_BIAS_REGULATOR_CYC   = T_INTERNAL_BIAS_REGULATOR_MS * (CLK_HZ / 1000);
  localparam int TMR_W      = 21;

  // Register indices.
  localparam logic [7:0] IDX_PATH = 8'h13;
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_STAT = 8'h21;
  localparam logic [7:0] IDX_LIM  = 8'h22;

  // Field positions.
  localparam int PATH_EN1_BIT = 6;
  localparam int PATH_EN2_BIT = 7;
  localparam int CTRL_GDIS    = 0;
  localparam int STAT_PRES1   = 0;
  localparam int STAT_PRES2   = 1;
  localparam int STAT_BUSP    = 2;
  localparam int STAT_INTERNAL_BIAS_REGULATOR    = 3;
  localparam int STAT_CONV    = 4;
  localparam int STAT_OFF     = 5;
  localparam int STAT_STATE   = 8;
  localparam int STAT_PROGRAM_RESISTOR_PIN    = 12;
  localparam int LIM_VLIM     = 0;
  localparam int LIM_ILIM     = 8;
  localparam int LIM_SRC      = 20;

  // Field widths and reset values.
  localparam int VLIM_W = 8;
  localparam int ILIM_W = 9;
  localparam int SRC_W  = 4;
  localparam int PROGRAM_RESISTOR_PIN_W = 3;
  localparam logic [VLIM_W-1:0] VLIM_RST = 8'h00;
  localparam logic [ILIM_W-1:0] ILIM_RST = 9'h000;
  localparam logic [SRC_W-1:0]  SRC_RST  = 4'h0;
  localparam logic              GDIS_RST = 1'b0;

  // Power-up sequence, Gray coded along the normal path.
  typedef enum logic [2:0] {
    ST_DETECT = 3'b000,
    ST_WAITBUS = 3'b001,
    ST_REGDLY = 3'b011,
    ST_QUAL   = 3'b010,
    ST_LIMITS = 3'b110,
    ST_SRCDET = 3'b111,
    ST_RUN    = 3'b101
  } dps_state_type;

  // Asynchronous pin inputs that need synchronising.
  typedef struct packed {
    logic input_one;
    logic input_two;
    logic bus_in;
    logic fault_one;
    logic fault_two;
    logic qual_pass;
    logic srcdet_done;
  } dps_pins_type;

  // Captured AHB address phase.
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] idx;
  } dps_aphase_type;
endpackage
`default_nettype wire

// file: dps_sequencer.sv
// Purpose: Power-up sequencing and dual input path selection with an AHB-Lite register bank.
// Assumes: Synchronous active-low power-on reset, one 10 MHz clock, analog sense on pins.
// Notes:   Reads take one wait state so a read right after a write sees the new value.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RQ1] First detect switch presence and program resistor, then load power-on defaults.
// [RQ2] Drive gate of detected switch; with two switches, first present input wins.
// [RQ3] Register access accepted only 20 ms after power arrives.
// [RQ4] Bus presence sets status bit; regulator turns on 128 ms later.
// [RQ5] Qualification test starts only once the regulator is on.
// [RQ6] After qualification load voltage limit, clamp current limit, run source detection.
// [RQ7] Converter starts switching last, after limits and source detection.
// [RQ8] Presence of each external switch is recorded in its own status bit.
// [RQ9] No switches: both presence bits zero, both enables locked zero.
// [RQ10] Only switch one: status one set, enable two locked zero, gate two low.
// [RQ11] Only switch one: input one present sets enable one and gate one.
// [RQ12] Only switch one: host clear of enable one ignored; global disable forces it off.
// [RQ13] Host sets global disable and waits for switch off before using bus input.
// [RQ14] Host removes bus, clears global disable; device re-enables path one.
// [RQ15] Both switches detected: both presence bits set.
// [RQ16] Dual: only first present path enabled; the other stays off.
// [RQ17] Host write setting both enables to 11 is ignored.
// [RQ18] Dual with one valid input: host write 00 rejected; only global disable works.
// [RQ19] Dual with both valid: write 00 or global disable turns both off.
// [RQ20] Dual, both valid: host write 01 to 10 switches path, and back.
// [RQ21] Fault on active path switches automatically to the other valid input.
// [RQ22] Active input lost while other valid: switchover completes without host.
// [RQ23] After switching to two, stay there until two invalid or host writes 01.
// [RQ24] Enable bits read back actual switch state; writes turn switches on or off.
// [RQ25] Protection faults turn the related switch off.
// [RQ26] Simultaneous arrival in dual configuration gives path one priority.
module dps_sequencer #(
  parameter int READY_CYCLES = dps_pkg::READY_CYC,
  parameter int INTERNAL_BIAS_REGULATOR_CYCLES  = dps_pkg::INTERNAL_BIAS_REGULATOR_CYC
) (
  // Clock and reset.
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  // AHB-Lite slave.
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic                      hready,
  input  wire logic [31:0]               hwdata,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // Sense pins and detection results.
  input  wire dps_pkg::dps_pins_type     i_pins,
  input  wire logic                      i_switch_one_detected,
  input  wire logic                      i_switch_two_detected,
  input  wire logic [dps_pkg::PROGRAM_RESISTOR_PIN_W-1:0] i_program_resistor_pin,
  input  wire logic [dps_pkg::VLIM_W-1:0] i_adc_vbus_limit,
  input  wire logic [dps_pkg::ILIM_W-1:0] i_adc_limit_pin,
  input  wire logic [dps_pkg::SRC_W-1:0]  i_srcdet_type,
  input  wire logic [dps_pkg::ILIM_W-1:0] i_srcdet_ilim,
  // Drives.
  output logic                           o_path_one_gate_drive,
  output logic                           o_path_two_gate_drive,
  output logic                           o_internal_bias_regulator,
  output logic                           o_qual_start,
  output logic                           o_srcdet_start,
  output logic                           o_converter_enable,
  output logic                           o_bus_ready
);
  import dps_pkg::*;

  localparam int NPIN = $bits(dps_pins_type);

  dps_state_type       state_r;
  logic [NPIN-1:0]     s1_r, s2_r, s3_r, filt_r;
  dps_pins_type        pin;
  logic [TMR_W-1:0]    rdy_cnt_r, tmr_r;
  logic                pres1_r, pres2_r, busp_r, gdis_r, off_r;
  logic                en1_nxt, en2_nxt, off_nxt;
  logic [PROGRAM_RESISTOR_PIN_W-1:0]   program_resistor_pin_r;
  logic [VLIM_W-1:0]   vlim_r;
  logic [ILIM_W-1:0]   ilim_r;
  logic [SRC_W-1:0]    src_r;
  dps_aphase_type      ap_r;
  logic                rd_pend_r;
  logic                v1, v2, wr_path, wr_ctrl;
  logic [1:0]          wpair;

  // Register index match, used by both write and read decoding.
  function automatic logic hit(input dps_aphase_type a, input logic [7:0] idx);
    hit = a.valid && (a.idx == idx);
  endfunction

  // Three-stage synchronisers; a change counts once stages two and three agree.
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
          s1_r[g]   <= 1'b0;
          s2_r[g]   <= 1'b0;
          s3_r[g]   <= 1'b0;
          filt_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= i_pins[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) begin
            filt_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate
  assign pin = dps_pins_type'(filt_r);

  // An input counts as valid while present and free of a protection fault.
  assign v1 = pin.input_one && !pin.fault_one; // RQ25
  assign v2 = pin.input_two && !pin.fault_two; // RQ25

  // Register access window opens a fixed time after power-on reset releases.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rdy_cnt_r   <= '0;
      o_bus_ready <= 1'b0;
    end else if (!o_bus_ready) begin
      if (rdy_cnt_r == TMR_W'(READY_CYCLES - 1)) begin
        o_bus_ready <= 1'b1; // RQ3
      end else begin
        rdy_cnt_r <= rdy_cnt_r + 1'b1;
      end
    end
  end

  // AHB address phase capture; reads get one wait state, writes none.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ap_r      <= '0;
      rd_pend_r <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        hreadyout <= 1'b1;
        ap_r      <= '0;
      end else if (hready) begin
        ap_r.valid <= hsel && htrans[1] && (haddr[31:10] == 22'h00_0000);
        ap_r.write <= hwrite;
        ap_r.idx   <= haddr[9:2];
        if (hsel && htrans[1] && !hwrite) begin
          rd_pend_r <= 1'b1;
          hreadyout <= 1'b0;
        end
      end
    end
  end

  // Writes land in the data phase; before the access window they are dropped.
  assign wr_path = hit(ap_r, IDX_PATH) && ap_r.write && o_bus_ready; // RQ3
  assign wr_ctrl = hit(ap_r, IDX_CTRL) && ap_r.write && o_bus_ready; // RQ3
  assign wpair   = {hwdata[PATH_EN2_BIT], hwdata[PATH_EN1_BIT]};

  // Read data, sampled in the wait state so earlier writes are visible.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata <= 32'h0000_0000;
      if (!o_bus_ready) begin
        hrdata <= 32'h0000_0000; // RQ3
      end else if (hit(ap_r, IDX_PATH)) begin
        hrdata[PATH_EN2_BIT] <= o_path_two_gate_drive; // RQ24
        hrdata[PATH_EN1_BIT] <= o_path_one_gate_drive; // RQ24
      end else if (hit(ap_r, IDX_CTRL)) begin
        hrdata[CTRL_GDIS] <= gdis_r;
      end else if (hit(ap_r, IDX_STAT)) begin
        hrdata[STAT_PRES1] <= pres1_r;
        hrdata[STAT_PRES2] <= pres2_r;
        hrdata[STAT_BUSP]  <= busp_r;
        hrdata[STAT_INTERNAL_BIAS_REGULATOR]  <= o_internal_bias_regulator;
        hrdata[STAT_CONV]  <= o_converter_enable;
        hrdata[STAT_OFF]   <= off_r;
        hrdata[STAT_STATE +: 3]      <= state_r;
        hrdata[STAT_PROGRAM_RESISTOR_PIN +: PROGRAM_RESISTOR_PIN_W]  <= program_resistor_pin_r;
      end else if (hit(ap_r, IDX_LIM)) begin
        hrdata[LIM_VLIM +: VLIM_W] <= vlim_r;
        hrdata[LIM_ILIM +: ILIM_W] <= ilim_r;
        hrdata[LIM_SRC +: SRC_W]   <= src_r;
      end
    end
  end

  // Global path disable control bit.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      gdis_r <= GDIS_RST;
    end else if (wr_ctrl) begin
      gdis_r <= hwdata[CTRL_GDIS]; // RQ13
    end
  end

  // Power-up sequence: detect, wait for bus, regulator delay, qualify, limits, source detection, run.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_r                   <= ST_DETECT;
      tmr_r                     <= '0;
      pres1_r                   <= 1'b0;
      pres2_r                   <= 1'b0;
      program_resistor_pin_r                    <= '0;
      busp_r                    <= 1'b0;
      vlim_r                    <= VLIM_RST;
      ilim_r                    <= ILIM_RST;
      src_r                     <= SRC_RST;
      o_internal_bias_regulator <= 1'b0;
      o_qual_start              <= 1'b0;
      o_srcdet_start            <= 1'b0;
      o_converter_enable        <= 1'b0;
    end else begin
      case (state_r)
        ST_DETECT: begin
          pres1_r <= i_switch_one_detected; // RQ8 RQ15
          pres2_r <= i_switch_two_detected; // RQ8 RQ15
          program_resistor_pin_r  <= i_program_resistor_pin; // RQ1
          state_r <= ST_WAITBUS; // RQ1
        end
        ST_WAITBUS: begin
          if (pin.bus_in) begin
            busp_r  <= 1'b1; // RQ4
            tmr_r   <= '0;
            state_r <= ST_REGDLY;
          end
        end
        ST_REGDLY: begin
          if (tmr_r == TMR_W'(INTERNAL_BIAS_REGULATOR_CYCLES - 1)) begin
            o_internal_bias_regulator <= 1'b1; // RQ4
            o_qual_start              <= 1'b1; // RQ5
            state_r                   <= ST_QUAL;
          end else begin
            tmr_r <= tmr_r + 1'b1;
          end
        end
        ST_QUAL: begin
          if (pin.qual_pass) begin
            o_qual_start <= 1'b0;
            state_r      <= ST_LIMITS;
          end
        end
        ST_LIMITS: begin
          vlim_r         <= i_adc_vbus_limit; // RQ6
          ilim_r         <= i_adc_limit_pin; // RQ6
          o_srcdet_start <= 1'b1; // RQ6
          state_r        <= ST_SRCDET;
        end
        ST_SRCDET: begin
          if (pin.srcdet_done) begin
            src_r <= i_srcdet_type; // RQ6
            // The detected limit never exceeds the limit-pin clamp.
            ilim_r <= (i_srcdet_ilim < ilim_r) ? i_srcdet_ilim : ilim_r; // RQ6
            o_srcdet_start     <= 1'b0;
            o_converter_enable <= 1'b1; // RQ7
            state_r            <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_DETECT;
        end
      endcase
    end
  end

  // Path selection. Host writes first, then faults, automatic choice, global disable and locks.
  always_comb begin
    en1_nxt = o_path_one_gate_drive;
    en2_nxt = o_path_two_gate_drive;
    off_nxt = off_r;
    if (wr_path && pres1_r && pres2_r && (wpair != 2'b11)) begin // RQ17
      if (wpair == 2'b00) begin
        if (v1 && v2) begin // RQ18
          en1_nxt = 1'b0; // RQ19
          en2_nxt = 1'b0; // RQ19
          off_nxt = 1'b1;
        end
      end else if (wpair == 2'b01 && v1) begin
        en1_nxt = 1'b1; // RQ20
        en2_nxt = 1'b0; // RQ20
        off_nxt = 1'b0;
      end else if (wpair == 2'b10 && v2) begin
        en1_nxt = 1'b0; // RQ20
        en2_nxt = 1'b1; // RQ20
        off_nxt = 1'b0;
      end
    end
    // Writes in the single-switch case are ignored; the path follows its input.
    // A host off request only holds while both inputs stay valid.
    if (!(v1 && v2)) begin
      off_nxt = 1'b0; // RQ18
    end
    // Faults or loss drop the active path and hand over to the other one if it is valid.
    if (en1_nxt && !v1) begin
      en1_nxt = 1'b0; // RQ25
      en2_nxt = v2; // RQ21 RQ22
    end
    if (en2_nxt && !v2) begin
      en2_nxt = 1'b0; // RQ25
      en1_nxt = v1; // RQ21 RQ22 RQ23
    end
    // With nothing on and no host off request, connect the first valid input; path one wins a tie.
    if (!en1_nxt && !en2_nxt && !off_nxt) begin
      if (v1) begin
        en1_nxt = 1'b1; // RQ2 RQ11 RQ14 RQ16 RQ26
      end else if (v2) begin
        en2_nxt = 1'b1; // RQ2 RQ16
      end
    end
    if (gdis_r) begin
      en1_nxt = 1'b0; // RQ12 RQ18 RQ19
      en2_nxt = 1'b0; // RQ12 RQ19
    end
    if (!pres1_r) begin
      en1_nxt = 1'b0; // RQ9
    end
    if (!pres2_r) begin
      en2_nxt = 1'b0; // RQ9 RQ10
    end
    if (state_r == ST_DETECT) begin
      en1_nxt = 1'b0; // RQ1
      en2_nxt = 1'b0;
    end
  end

  // Gate drives are the enable bits themselves, so reads show true switch state.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_path_one_gate_drive <= 1'b0;
      o_path_two_gate_drive <= 1'b0;
      off_r                 <= 1'b0;
    end else begin
      o_path_one_gate_drive <= en1_nxt; // RQ24
      o_path_two_gate_drive <= en2_nxt; // RQ24
      off_r                 <= off_nxt;
    end
  end

  // Checks.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  never_both_on_a: assert property (!(o_path_one_gate_drive && o_path_two_gate_drive)) // RQ17
    else $error("both input paths enabled");
  lock_two_a: assert property (!pres2_r |-> !o_path_two_gate_drive) // RQ10
    else $error("path two on without its switch");
  lock_none_a: assert property (!pres1_r && !pres2_r |-> !o_path_one_gate_drive) // RQ9
    else $error("path one on with no switches");
  gdis_forces_off_a: assert property (gdis_r |=> !o_path_one_gate_drive && !o_path_two_gate_drive) // RQ12
    else $error("global disable did not turn paths off");
  internal_bias_regulator_delay_a: assert property ($rose(o_internal_bias_regulator) |-> // RQ4
      $past(state_r) == ST_REGDLY && $past(tmr_r) == TMR_W'(INTERNAL_BIAS_REGULATOR_CYCLES - 1))
    else $error("regulator delay wrong");
  qual_after_internal_bias_regulator_a: assert property (o_qual_start |-> o_internal_bias_regulator) // RQ5
    else $error("qualification before regulator on");
  conv_last_a: assert property ($rose(o_converter_enable) |-> // RQ7
      !o_srcdet_start && $past(state_r) == ST_SRCDET)
    else $error("converter started early");
  ready_time_a: assert property ($rose(o_bus_ready) |-> $past(rdy_cnt_r) == TMR_W'(READY_CYCLES - 1)) // RQ3
    else $error("access window opened at wrong time");
  auto_switch_a: assert property (o_path_one_gate_drive && !v1 && v2 && pres2_r && !gdis_r // RQ22
      |=> o_path_two_gate_drive)
    else $error("no automatic switchover to path two");

  switch_cov: cover property (o_path_one_gate_drive ##1 o_path_two_gate_drive);
  run_cov: cover property ($rose(o_converter_enable));
  host_off_cov: cover property ($rose(off_r));
endmodule
`default_nettype wire

// file: dps_far_side.sv
// Purpose: Model of the sources, switches and analog helpers around the sequencer.
// Assumes: The bench commands source and fault levels; answers follow the start levels.
// Notes:   Delays are short so that a run stays brief.
`timescale 1ns/1ps
`default_nettype none
module dps_far_side #(
  parameter int QUAL_DLY = 6,
  parameter int SRC_DLY  = 4
) (
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // Commanded source and fault levels.
  input  wire logic             i_src_one,
  input  wire logic             i_src_two,
  input  wire logic             i_src_bus,
  input  wire logic             i_ovp_one,
  input  wire logic             i_ovp_two,
  // Requests from the sequencer.
  input  wire logic             i_qual_start,
  input  wire logic             i_srcdet_start,
  // Sense pins.
  output dps_pkg::dps_pins_type o_pins
);
  import dps_pkg::*;

  logic [7:0] qual_cnt_r;
  logic [7:0] src_cnt_r;
  logic       qual_pass_r;
  logic       src_done_r;

  // Qualification counts only while the start is held; once raised, the pass stays high until reset.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      qual_cnt_r  <= 8'h00;
      qual_pass_r <= 1'b0;
    end else if (i_qual_start && !qual_pass_r) begin
      qual_cnt_r  <= qual_cnt_r + 8'h01;
      qual_pass_r <= (qual_cnt_r == 8'(QUAL_DLY));
    end
  end

  // Source detection answers a held start after a short delay; the result is sticky.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      src_cnt_r  <= 8'h00;
      src_done_r <= 1'b0;
    end else if (i_srcdet_start && !src_done_r) begin
      src_cnt_r  <= src_cnt_r + 8'h01;
      src_done_r <= (src_cnt_r == 8'(SRC_DLY));
    end
  end

  // Pin levels in the order of the pin struct, first member highest.
  assign o_pins = {i_src_one, i_src_two, i_src_bus, i_ovp_one, i_ovp_two, qual_pass_r, src_done_r};
endmodule
`default_nettype wire

// file: tb_top.sv
// Purpose: Self-checking bench for the dual input power path sequencer.
// Assumes: Shortened ready and regulator delays; one AHB-Lite master.
// Notes:   Each scenario resets the block with its own switch population.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dps_pkg::*;
  localparam int RDY = 20;
  localparam int RGD = 30;

  logic         i_clk     = 1'b0;
  logic         i_reset_n = 1'b0;
  logic         hsel      = 1'b0;
  logic [31:0]  haddr     = 32'h0000_0000;
  logic [1:0]   htrans    = 2'b00;
  logic         hwrite    = 1'b0;
  logic [2:0]   hsize     = 3'b010;
  logic [31:0]  hwdata    = 32'h0000_0000;
  logic         hreadyout;
  logic         hresp;
  logic [31:0]  hrdata;
  logic         src_one   = 1'b0;
  logic         src_two   = 1'b0;
  logic         src_bus   = 1'b0;
  logic         ovp_one   = 1'b0;
  logic         ovp_two   = 1'b0;
  logic         det_one   = 1'b0;
  logic         det_two   = 1'b0;
  logic [2:0]   program_resistor_pin      = 3'h0;
  dps_pins_type pins;
  logic         g_one;
  logic         g_two;
  logic         reg_on;
  logic         qual_st;
  logic         src_st;
  logic         conv_en;
  logic         bus_rdy;
  int           errors    = 0;
  int           cmp_count = 0;

  // Free-running core clock.
  always #50 i_clk = ~i_clk;

  dps_sequencer #(.READY_CYCLES(RDY), .INTERNAL_BIAS_REGULATOR_CYCLES(RGD)) i_dps_sequencer (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .i_pins(pins),
    .i_switch_one_detected(det_one), .i_switch_two_detected(det_two),
    .i_program_resistor_pin(program_resistor_pin), .i_adc_vbus_limit(8'h5a), .i_adc_limit_pin(9'h064),
    .i_srcdet_type(4'h9), .i_srcdet_ilim(9'h0c8), .o_path_one_gate_drive(g_one),
    .o_path_two_gate_drive(g_two), .o_internal_bias_regulator(reg_on),
    .o_qual_start(qual_st), .o_srcdet_start(src_st), .o_converter_enable(conv_en),
    .o_bus_ready(bus_rdy));

  dps_far_side i_dps_far_side (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_src_one(src_one), .i_src_two(src_two),
    .i_src_bus(src_bus), .i_ovp_one(ovp_one), .i_ovp_two(ovp_two),
    .i_qual_start(qual_st), .i_srcdet_start(src_st), .o_pins(pins));

  // Verdict and end of run; every bounded wait that runs out also lands here.
  task automatic close_out;
    $display("comparisons=%0d mismatches=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single word transfer; the request is held until hready is sampled high.
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    haddr  <= {22'h00_0000, idx, 2'b00};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      errors++;
      close_out();
    end
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge i_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 80);
    rd = hrdata;
    if (hreadyout !== 1'b1) begin
      errors++;
      close_out();
    end
    // The slave never reports an error response.
    chk(32'(hresp), 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, idx, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, idx, 32'h0000_0000, x);
    chk(x & m, e);
  endtask

  // Reset with a given switch population; the program code follows it, so runs with the same population share a code.
  task automatic rst(input logic d1, input logic d2);
    i_reset_n <= 1'b0;
    det_one   <= d1;
    det_two   <= d2;
    program_resistor_pin      <= {d1, d2, 1'b1};
    {src_one, src_two, src_bus, ovp_one, ovp_two} <= 5'h00;
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    while (bus_rdy !== 1'b1 && n < 60) begin
      @(posedge i_clk);
      n++;
    end
    chk(32'(bus_rdy), 32'h0000_0001);
    if (bus_rdy !== 1'b1) begin
      close_out();
    end
  endtask

  task automatic wait_g(input logic [1:0] e);
    int n;
    n = 0;
    while ({g_two, g_one} !== e && n < 30) begin
      @(posedge i_clk);
      n++;
    end
    chk(32'({g_two, g_one}), 32'(e));
    if ({g_two, g_one} !== e) begin
      close_out();
    end
  endtask

  task automatic hold(input logic [1:0] e);
    repeat (12) @(posedge i_clk);
    chk(32'({g_two, g_one}), 32'(e));
  endtask

  task automatic t_seq;
    int n;
    rst(1'b1, 1'b1);
    wr(IDX_CTRL, 32'h0000_0001);
    rd_chk(IDX_STAT, 32'hffff_ffff, 32'h0000_0000);
    wait_rdy();
    rd_chk(IDX_CTRL, 32'h0000_0001, 32'h0000_0000);
    rd_chk(IDX_STAT, 32'h0000_701f, 32'h0000_7003);
    src_bus <= 1'b1;
    n = 0;
    while (reg_on !== 1'b1 && n < 80) begin
      @(posedge i_clk);
      n++;
    end
    chk(32'(n >= RGD && n < RGD + 8), 32'h0000_0001);
    if (reg_on !== 1'b1) begin
      close_out();
    end
    chk(32'(qual_st), 32'h0000_0001);
    rd_chk(IDX_STAT, 32'h0000_000c, 32'h0000_000c);
    n = 0;
    while (conv_en !== 1'b1 && n < 80) begin
      @(posedge i_clk);
      n++;
    end
    chk(32'({conv_en, src_st, qual_st}), 32'h0000_0004);
    if (conv_en !== 1'b1) begin
      close_out();
    end
    rd_chk(IDX_LIM, 32'h00ff_ffff, 32'h0090_645a);
    $display("done: power-up sequence");
  endtask

  task automatic t_none;
    rst(1'b0, 1'b0);
    wait_rdy();
    rd_chk(IDX_STAT, 32'h0000_0003, 32'h0000_0000);
    src_one <= 1'b1;
    src_two <= 1'b1;
    wr(IDX_PATH, 32'h0000_0040);
    hold(2'b00);
    rd_chk(IDX_PATH, 32'h0000_00c0, 32'h0000_0000);
    wr(8'h30, 32'hffff_ffff);
    rd_chk(8'h30, 32'hffff_ffff, 32'h0000_0000);
    $display("done: no switches");
  endtask

  task automatic t_single;
    rst(1'b1, 1'b0);
    wait_rdy();
    rd_chk(IDX_STAT, 32'h0000_0003, 32'h0000_0001);
    src_one <= 1'b1;
    src_two <= 1'b1;
    wait_g(2'b01);
    wr(IDX_PATH, 32'h0000_0080);
    hold(2'b01);
    wr(IDX_PATH, 32'h0000_0000);
    hold(2'b01);
    ovp_one <= 1'b1;
    wait_g(2'b00);
    ovp_one <= 1'b0;
    wait_g(2'b01);
    wr(IDX_CTRL, 32'h0000_0001);
    wait_g(2'b00);
    src_bus <= 1'b1;
    rd_chk(IDX_PATH, 32'h0000_00c0, 32'h0000_0000);
    src_bus <= 1'b0;
    wr(IDX_CTRL, 32'h0000_0000);
    wait_g(2'b01);
    $display("done: single switch");
  endtask

  task automatic t_dual;
    rst(1'b1, 1'b1);
    wait_rdy();
    src_two <= 1'b1;
    wait_g(2'b10);
    src_one <= 1'b1;
    hold(2'b10);
    wr(IDX_PATH, 32'h0000_00c0);
    hold(2'b10);
    wr(IDX_PATH, 32'h0000_0040);
    wait_g(2'b01);
    rd_chk(IDX_PATH, 32'h0000_00c0, 32'h0000_0040);
    wr(IDX_PATH, 32'h0000_0080);
    wait_g(2'b10);
    ovp_two <= 1'b1;
    wait_g(2'b01);
    ovp_two <= 1'b0;
    hold(2'b01);
    ovp_one <= 1'b1;
    wait_g(2'b10);
    ovp_one <= 1'b0;
    hold(2'b10);
    wr(IDX_PATH, 32'h0000_0040);
    wait_g(2'b01);
    src_one <= 1'b0;
    wait_g(2'b10);
    wr(IDX_PATH, 32'h0000_0000);
    hold(2'b10);
    wr(IDX_CTRL, 32'h0000_0001);
    wait_g(2'b00);
    wr(IDX_CTRL, 32'h0000_0000);
    wait_g(2'b10);
    src_one <= 1'b1;
    hold(2'b10);
    wr(IDX_PATH, 32'h0000_0000);
    wait_g(2'b00);
    $display("done: dual switches");
  endtask

  task automatic t_tie;
    rst(1'b1, 1'b1);
    wait_rdy();
    src_one <= 1'b1;
    src_two <= 1'b1;
    wait_g(2'b01);
    hold(2'b01);
    $display("done: simultaneous arrival");
  endtask

  // Main sequence.
  initial begin
    t_seq();
    t_none();
    t_single();
    t_dual();
    t_tie();
    close_out();
  end
endmodule
`default_nettype wire
